// file: inc/dif_pkg.sv
// Shared constants and types for the protection tuple engine
package dif_pkg;

  // Guard CRC polynomial without its top term, and inverted seed
  localparam logic [15:0] GUARD_POLY   = 16'h8BB7;
  localparam logic [15:0] GUARD_ZERO   = 16'h0000;
  localparam logic [15:0] GUARD_INV    = 16'hFFFF;

  // Supported block sizes in data bytes
  localparam logic [12:0] BLK_512      = 13'h0200;
  localparam logic [12:0] BLK_520      = 13'h0208;
  localparam logic [12:0] BLK_4096     = 13'h1000;
  localparam logic [12:0] BLK_4104     = 13'h1008;

  // Tuple geometry
  localparam logic [31:0] TUPLE_BYTES  = 32'h0000_0008;
  localparam logic [12:0] TUPLE_LAST   = 13'h0007;
  localparam logic [12:0] CNT_ZERO     = 13'h0000;

  // Output FIFO geometry
  localparam int          FIFO_WIDTH   = 8;
  localparam int          FIFO_DEPTH   = 4;

  typedef enum logic [2:0] {
    OP_CHECK    = 3'b000,
    OP_STRIP    = 3'b001,
    OP_INSERT   = 3'b010,
    OP_UPDATE   = 3'b011,
    OP_GENERATE = 3'b100
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DATA = 3'b001,
    ST_TIN  = 3'b010,
    ST_EVAL = 3'b011,
    ST_TOUT = 3'b100,
    ST_NEXT = 3'b101,
    ST_DONE = 3'b110
  } state_e;

  typedef struct packed {
    op_e         op;
    logic [1:0]  blockSize;
    logic        chkGuard;
    logic        chkApp;
    logic        chkRef;
    logic        invSeed;
    logic        invResult;
    logic        srcAppInc;
    logic        srcRefInc;
    logic        dstAppInc;
    logic        dstRefInc;
    logic [31:0] transferSize;
    logic [15:0] srcAppSeed;
    logic [31:0] srcRefSeed;
    logic [15:0] dstAppSeed;
    logic [31:0] dstRefSeed;
  } cfg_s;

  typedef struct packed {
    logic guardFail;
    logic appFail;
    logic refFail;
  } fail_s;

  typedef struct packed {
    logic [31:0] bytesDone;
    logic [15:0] srcApp;
    logic [31:0] srcRef;
    logic [15:0] dstApp;
    logic [31:0] dstRef;
    fail_s       fail;
  } result_s;

endpackage

// file: verification/dif_strip_update_generate_bench.sv
// Self-checking bench for the protection tuple engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  n_fail++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module dif_strip_update_generate_bench
  import dif_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  logic        clr = 1'b0;
  logic        stallOut = 1'b0;
  logic [15:0] srcLen = 16'h0000;
  cfg_s        cfgIn = '0;
  cfg_s        c;
  logic [7:0]  inData;
  logic        inValid;
  logic        inReady;
  logic [7:0]  outData;
  logic        outValid;
  logic        outReady;
  logic        busy;
  logic        donePulse;
  result_s     result;
  logic [7:0]  expMem [0:8191];
  int          expLen;
  int          sp;
  int          n_fail = 0;
  int          checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  dif_engine dif_engine_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .start(start), .cfg(cfgIn), .inData(inData), .inValid(inValid),
    .inReady(inReady), .outData(outData), .outValid(outValid),
    .outReady(outReady), .busy(busy), .donePulse(donePulse),
    .result(result));
  host_model host_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clr(clr),
    .srcLen(srcLen), .stallOut(stallOut), .inData(inData),
    .inValid(inValid), .inReady(inReady), .outData(outData),
    .outValid(outValid), .outReady(outReady));

  ////////////////////////////////////////////////////////////////////////////
  // Reference guard step, MSB first
  function automatic logic [15:0] crcByte(logic [15:0] r, logic [7:0] d);
    r = r ^ {d, 8'h00};
    for (int k = 0; k < 8; k++) begin
      r = r[15] ? ((r << 1) ^ GUARD_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Tag for block b; 32-bit add wraps to zero
  function automatic logic [31:0] tg(logic [31:0] s, bit inc, int b);
    return s + (inc ? 32'(b) : 32'h0000_0000);
  endfunction

  // Tuple bytes go out most significant first
  task automatic put(bit toSrc, logic [63:0] t);
    for (int k = 0; k < 8; k++) begin
      if (toSrc) begin
        host_model_inst.srcMem[sp] = t[63-8*k -: 8];
        sp++;
      end else begin
        expMem[expLen] = t[63-8*k -: 8];
        expLen++;
      end
    end
  endtask

  // Source image and expected destination, one fault block optional
  task automatic fill(int nBlk, int bad, bit badG);
    int          blkBytes;
    bit          flip;
    logic [15:0] g;
    logic [7:0]  d;
    blkBytes = (c.blockSize == 2'h0) ? 512 : (c.blockSize == 2'h1) ? 520 :
               (c.blockSize == 2'h2) ? 4096 : 4104;
    sp = 0;
    expLen = 0;
    for (int b = 0; b < nBlk; b++) begin
      g = c.invSeed ? GUARD_INV : GUARD_ZERO;
      for (int i = 0; i < blkBytes; i++) begin
        d = 8'(b * 13 + i * 7 + 3);
        host_model_inst.srcMem[sp] = d;
        sp++;
        g = crcByte(g, d);
        if (c.op inside {OP_STRIP, OP_INSERT, OP_UPDATE}) begin
          expMem[expLen] = d;
          expLen++;
        end
      end
      g = c.invResult ? ~g : g;
      if (c.op inside {OP_CHECK, OP_STRIP, OP_UPDATE}) begin
        // A tag fault corrupts both application and reference tags
        flip = !badG && b == bad;
        put(1, {g ^ {15'h0000, badG && b == bad},
                16'(tg(32'(c.srcAppSeed), c.srcAppInc, b)) ^ {15'h0000, flip},
                tg(c.srcRefSeed, c.srcRefInc, b) ^ {31'h0, flip}});
      end
      if (c.op inside {OP_INSERT, OP_UPDATE, OP_GENERATE}) begin
        put(0, {g, 16'(tg(32'(c.dstAppSeed), c.dstAppInc, b)),
                tg(c.dstRefSeed, c.dstRefInc, b)});
      end
    end
    c.transferSize = 32'(sp);
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait at falling edges where outputs are settled
  task automatic waitLow(bit pulse, int lim);
    int n;
    n = 0;
    while ((pulse ? donePulse !== 1'b1 : (outValid !== 1'b0 || busy !== 1'b0))
           && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      n_fail++;
      end_of_test();
    end
  endtask

  // One job; poke sends a second start while busy, with another op
  task automatic run(int nBlk, int bad, bit badG, bit poke);
    fill(nBlk, bad, badG);
    @(posedge clk_sys);
    clr <= 1'b1;
    srcLen <= 16'(sp);
    cfgIn <= c;
    @(posedge clk_sys);
    clr <= 1'b0;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    if (poke) begin
      repeat (4) @(posedge clk_sys);
      start <= 1'b1;
      cfgIn.op <= OP_GENERATE;
      @(posedge clk_sys);
      start <= 1'b0;
    end
    waitLow(1, 40000);
    waitLow(0, 400);
  endtask

  task automatic outChk();
    `CHK("dstLen", 16'(expLen), host_model_inst.wrCnt)
    for (int k = 0; k < expLen; k++) begin
      `CHK("dstByte", expMem[k], host_model_inst.dstMem[k])
    end
  endtask

  task automatic resChk(logic [31:0] bd, logic [15:0] sA, logic [31:0] sR,
                        logic [15:0] dA, logic [31:0] dR, fail_s f);
    `CHK("bytesDone", bd, result.bytesDone)
    `CHK("srcApp", sA, result.srcApp)
    `CHK("srcRef", sR, result.srcRef)
    `CHK("dstApp", dA, result.dstApp)
    `CHK("dstRef", dR, result.dstRef)
    `CHK("fail", f, result.fail)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Strip, all checks on, source ref wraps, output stalled, start poked
  task automatic t_strip_ok();
    c = '0;
    c.op = OP_STRIP;
    {c.chkGuard, c.chkApp, c.chkRef, c.srcAppInc, c.srcRefInc} = 5'h1F;
    c.srcAppSeed = 16'h1234;
    c.srcRefSeed = 32'hFFFF_FFFF;
    stallOut <= 1'b1;
    run(2, -1, 0, 1);
    outChk();
    resChk(32'h410, 16'h1236, 32'h1, 16'h0, 32'h0, '0);
  endtask

  // Strip, wrong application and reference tags in second block stop the job there
  task automatic t_strip_fail();
    c.op = OP_STRIP;
    c.srcRefSeed = 32'h0000_0100;
    stallOut <= 1'b0;
    run(3, 1, 0, 0);
    resChk(32'h208, 16'h1235, 32'h101, 16'h0, 32'h0, 3'b011);
  endtask

  // Update of 520-byte blocks, guard check off, guard seed and result inverted
  task automatic t_update();
    c = '0;
    c.op = OP_UPDATE;
    c.blockSize = 2'h1;
    {c.chkApp, c.chkRef, c.invSeed, c.invResult} = 4'hF;
    {c.srcRefInc, c.dstAppInc} = 2'h3;
    c.srcAppSeed = 16'hA5A5;
    c.srcRefSeed = 32'h0000_0010;
    c.dstAppSeed = 16'h0FFF;
    c.dstRefSeed = 32'h7000_0000;
    stallOut <= 1'b1;
    run(2, -1, 0, 0);
    outChk();
    resChk(32'h420, 16'hA5A5, 32'h12, 16'h1001,
           32'h7000_0000, '0);
  endtask

  // Update with a corrupt guard in the first block
  task automatic t_update_guard();
    c.chkGuard = 1'b1;
    stallOut <= 1'b0;
    run(2, 0, 1, 0);
    resChk(32'h0, 16'hA5A5, 32'h10, 16'h0FFF,
           32'h7000_0000, 3'b100);
  endtask

  // Generate over every block size; destination ref wraps
  task automatic t_generate();
    logic [31:0] blkBytes;
    for (int s = 0; s < 4; s++) begin
      c = '0;
      c.op = OP_GENERATE;
      c.blockSize = 2'(s);
      {c.dstAppInc, c.dstRefInc} = 2'h3;
      c.dstAppSeed = 16'h00FE;
      c.dstRefSeed = 32'hFFFF_FFFF;
      run(1, -1, 0, 0);
      blkBytes = c.transferSize;
      outChk();
      resChk(blkBytes, 16'h0, 32'h0, 16'h00FF, 32'h0, '0);
    end
  endtask

  // Check writes nothing; insert appends a tuple and counts data bytes
  task automatic t_check_insert();
    c = '0;
    c.op = OP_CHECK;
    {c.chkGuard, c.chkApp} = 2'h3;
    c.srcAppSeed = 16'h4321;
    run(2, -1, 0, 0);
    outChk();
    resChk(32'h410, 16'h4321, 32'h0, 16'h0, 32'h0, '0);
    c = '0;
    c.op = OP_INSERT;
    c.dstRefInc = 1'b1;
    c.dstRefSeed = 32'h0000_0005;
    run(1, -1, 0, 0);
    outChk();
    resChk(32'h200, 16'h0, 32'h0, 16'h0, 32'h6, '0);
    // Empty transfer completes at once and leaves the seeds in place
    run(0, -1, 0, 0);
    outChk();
    resChk(32'h0, 16'h0, 32'h0, 16'h0, 32'h5, '0);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_strip_ok();
    t_strip_fail();
    t_update();
    t_update_guard();
    t_generate();
    t_check_insert();
    end_of_test();
  end
endmodule
`default_nettype wire

// file: verification/host_model.sv
// Host memory model: source byte feeder and destination byte sink
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clr,
  input  wire logic [15:0] srcLen,
  input  wire logic        stallOut,
  output logic      [7:0]  inData,
  output logic             inValid,
  input  wire logic        inReady,
  input  wire logic [7:0]  outData,
  input  wire logic        outValid,
  output logic             outReady
);
  logic [7:0]  srcMem [0:8191];
  logic [7:0]  dstMem [0:8191];
  logic [15:0] rdPtr;
  logic [15:0] wrCnt;
  logic [7:0]  lastByte;
  logic [2:0]  tick;

  ////////////////////////////////////////////////////////////////////////////
  // Offer holds until taken; an idle line shows the inverted last byte
  assign inValid = rdPtr < srcLen;
  assign inData  = inValid ? srcMem[rdPtr[12:0]] : ~lastByte;

  // Source pointer, rewound by clr before each job
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdPtr    <= 16'h0000;
      lastByte <= 8'h00;
    end else if (clr) begin
      rdPtr    <= 16'h0000;
    end else if (inValid && inReady) begin
      rdPtr    <= rdPtr + 16'h0001;
      lastByte <= inData;
    end
  end

  // Sink captures every accepted destination byte
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrCnt <= 16'h0000;
    end else if (clr) begin
      wrCnt <= 16'h0000;
    end else if (outValid && outReady) begin
      dstMem[wrCnt[12:0]] <= outData;
      wrCnt               <= wrCnt + 16'h0001;
    end
  end

  // Stall mode accepts one cycle in eight, enough to fill the FIFO
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick     <= 3'h0;
      outReady <= 1'b0;
    end else begin
      tick     <= tick + 3'h1;
      outReady <= !stallOut || (tick == 3'h0);
    end
  end
endmodule
`default_nettype wire

// file: verilog/dif_crc16.sv
// Byte-wide guard CRC step, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module dif_crc16
  import dif_pkg::*;
(
  input  wire logic [15:0] crcIn,
  input  wire logic [7:0]  dataIn,
  output logic      [15:0] crcOut
);

  logic [15:0] stage [0:8];

  assign stage[0] = crcIn;

  // One shift-and-reduce per data bit
  for (genvar i = 0; i < 8; i++) begin : g_bit
    logic fb;
    assign fb = stage[i][15] ^ dataIn[7-i];
    assign stage[i+1] = {stage[i][14:0], 1'b0} ^
                        (fb ? GUARD_POLY : GUARD_ZERO);
  end

  assign crcOut = stage[8];

endmodule
`default_nettype wire

// file: verilog/dif_engine.sv
// Protection tuple engine: check, strip, insert, update, generate
//
// Notes on behaviour
// R1 - Strip with guard check computes block CRC, compares to source guard.
// R2 - Strip optionally checks source application and reference tags.
// R3 - Strip forwards only data bytes; the source tuple is dropped.
// R4 - Strip advances expected tags per source increment flags.
// R5 - Strip output is block-size bytes per source block.
// R6 - Update always computes the guard CRC over block data.
// R7 - Update with guard check compares computed guard to source guard.
// R8 - Update optionally checks source application and reference tags.
// R9 - Update tuple is new guard plus destination application and reference.
// R10 - Update forwards data unchanged then the new tuple.
// R11 - Update advances expected source tags per source flags.
// R12 - Update advances destination tags independently per destination flags.
// R13 - Update output length equals source length.
// R14 - Bytes done counts source units: size plus 8, or size for insert and generate.
// R15 - Generate emits only guard plus current tags per block.
// R16 - Generate advances tags per destination flags.
// R17 - Generate output is 8 bytes per source block.
// R18 - Block size is one of four values chosen at start.
// R19 - Guard CRC seed zero or all ones; result optionally inverted.
// R20 - Tags travel big-endian, most significant byte first.
// R21 - Incrementing tags add one and wrap; next-block value reported.
// R22 - On tag mismatch stop at that block, flag it, report prior bytes.
`timescale 1ns/1ps
`default_nettype none
module dif_engine
  import dif_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire cfg_s       cfg,
  input  wire logic [7:0] inData,
  input  wire logic       inValid,
  output logic            inReady,
  output logic      [7:0] outData,
  output logic            outValid,
  input  wire logic       outReady,
  output logic            busy,
  output logic            donePulse,
  output result_s         result
);

  ////////////////////////////////////////////////////////////////////////////
  // State and datapath registers

  state_e      state_ff;
  state_e      nxt_state;
  cfg_s        cfg_ff;
  logic [12:0] byteCnt_ff;
  logic [15:0] crc_ff;
  logic [63:0] tuple_ff;
  logic [15:0] expApp_ff;
  logic [31:0] expRef_ff;
  logic [15:0] dstApp_ff;
  logic [31:0] dstRef_ff;
  logic [31:0] bytesDone_ff;
  fail_s       fail_ff;
  logic        done_ff;

  logic [12:0] blkLen;
  logic        fwd;
  logic        hasTup;
  logic        emitTup;
  logic        take;
  logic        tupTake;
  logic        tupPush;
  logic [15:0] crcNext;
  logic [15:0] seedVal;
  logic [15:0] guardVal;
  logic [63:0] outTuple;
  logic [31:0] unitBytes;
  logic [31:0] nxtBytes;
  fail_s       evalFail;
  logic        anyFail;
  logic [7:0]  fifoInData;
  logic        fifoInValid;
  logic        fifoInReady;

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode

  // Block length lookup from the latched selector
  always_comb begin
    case (cfg_ff.blockSize)
      2'b00:   blkLen = BLK_512; // [R18]
      2'b01:   blkLen = BLK_520; // [R18]
      2'b10:   blkLen = BLK_4096; // [R18]
      default: blkLen = BLK_4104; // [R18]
    endcase
  end

  // Which parts of a block move where
  assign fwd     = cfg_ff.op == OP_STRIP || cfg_ff.op == OP_INSERT ||
                   cfg_ff.op == OP_UPDATE; // [R3] [R10]
  assign hasTup  = cfg_ff.op == OP_CHECK || cfg_ff.op == OP_STRIP ||
                   cfg_ff.op == OP_UPDATE;
  assign emitTup = cfg_ff.op == OP_INSERT || cfg_ff.op == OP_UPDATE ||
                   cfg_ff.op == OP_GENERATE; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // Stream handshakes

  // Data bytes stall on a full FIFO only when they are forwarded
  assign take    = state_ff == ST_DATA && inValid && (!fwd || fifoInReady);
  assign tupTake = state_ff == ST_TIN && inValid;
  assign tupPush = state_ff == ST_TOUT && fifoInReady;
  assign inReady = (state_ff == ST_DATA && (!fwd || fifoInReady)) ||
                   state_ff == ST_TIN;

  // Source tuple never reaches the FIFO
  assign fifoInValid = (state_ff == ST_DATA && fwd && inValid) ||
                       state_ff == ST_TOUT; // [R3]
  assign fifoInData  = (state_ff == ST_TOUT) ?
                       outTuple[63 - 8 * byteCnt_ff[2:0] -: 8] : // [R20]
                       inData; // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Guard and tuple assembly

  // Seed as a preloaded register equals XOR into the first 16 bits
  assign seedVal  = cfg.invSeed ? GUARD_INV : GUARD_ZERO; // [R19]
  assign guardVal = crc_ff ^
                    (cfg_ff.invResult ? GUARD_INV : GUARD_ZERO); // [R19]

  // Outgoing tuple always carries destination tags
  assign outTuple = {guardVal, dstApp_ff, dstRef_ff}; // [R9] [R15]

  dif_crc16 u_crc (
    .crcIn  (crc_ff),
    .dataIn (inData),
    .crcOut (crcNext)
  );

  // Enabled comparisons against the captured source tuple
  assign evalFail.guardFail = cfg_ff.chkGuard &&
                              tuple_ff[63:48] != guardVal; // [R1] [R7]
  assign evalFail.appFail   = cfg_ff.chkApp &&
                              tuple_ff[47:32] != expApp_ff; // [R2] [R8]
  assign evalFail.refFail   = cfg_ff.chkRef &&
                              tuple_ff[31:0] != expRef_ff; // [R2] [R8]
  assign anyFail = evalFail.guardFail || evalFail.appFail ||
                   evalFail.refFail;

  // Progress counted in source bytes
  assign unitBytes = {19'h0_0000, blkLen} +
                     ((cfg_ff.op == OP_INSERT || cfg_ff.op == OP_GENERATE) ?
                      32'h0000_0000 : TUPLE_BYTES); // [R14]
  assign nxtBytes  = bytesDone_ff + unitBytes;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = (cfg.transferSize == 32'h0000_0000) ? ST_DONE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (take && byteCnt_ff == blkLen - 13'h0001) begin
          nxt_state = hasTup ? ST_TIN : ST_TOUT; // [R5] [R17]
        end
      end
      ST_TIN: begin
        if (tupTake && byteCnt_ff == TUPLE_LAST) begin
          nxt_state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        if (anyFail) begin
          nxt_state = ST_DONE; // [R22]
        end else begin
          nxt_state = emitTup ? ST_TOUT : ST_NEXT;
        end
      end
      ST_TOUT: begin
        if (tupPush && byteCnt_ff == TUPLE_LAST) begin
          nxt_state = ST_NEXT; // [R13] [R17]
        end
      end
      ST_NEXT: begin
        nxt_state = (nxtBytes >= cfg_ff.transferSize) ? ST_DONE : ST_DATA;
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Configuration held steady for the whole job
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= '0;
    end else if (state_ff == ST_IDLE && start) begin
      cfg_ff <= cfg; // [R18]
    end
  end

  // Byte position inside the data or tuple section
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      byteCnt_ff <= CNT_ZERO;
    end else if (state_ff != nxt_state) begin
      byteCnt_ff <= CNT_ZERO;
    end else if (take || tupTake || tupPush) begin
      byteCnt_ff <= byteCnt_ff + 13'h0001;
    end
  end

  // Guard runs over every data byte, whatever the check enables
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crc_ff <= GUARD_ZERO;
    end else if (state_ff == ST_IDLE && start) begin
      crc_ff <= seedVal; // [R19]
    end else if (state_ff == ST_NEXT) begin
      crc_ff <= cfg_ff.invSeed ? GUARD_INV : GUARD_ZERO; // [R19]
    end else if (take) begin
      crc_ff <= crcNext; // [R6] [R1]
    end
  end

  // Source tuple shifts in, first byte ends up most significant
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tuple_ff <= '0;
    end else if (tupTake) begin
      tuple_ff <= {tuple_ff[55:0], inData}; // [R20]
    end
  end

  // Expected source tags; increments wrap by natural overflow
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      expApp_ff <= '0;
      expRef_ff <= '0;
    end else if (state_ff == ST_IDLE && start) begin
      expApp_ff <= cfg.srcAppSeed;
      expRef_ff <= cfg.srcRefSeed;
    end else if (state_ff == ST_NEXT && hasTup) begin
      if (cfg_ff.srcAppInc) begin
        expApp_ff <= expApp_ff + 16'h0001; // [R4] [R11] [R21]
      end
      if (cfg_ff.srcRefInc) begin
        expRef_ff <= expRef_ff + 32'h0000_0001; // [R4] [R11] [R21]
      end
    end
  end

  // Destination tags move on their own flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dstApp_ff <= '0;
      dstRef_ff <= '0;
    end else if (state_ff == ST_IDLE && start) begin
      dstApp_ff <= cfg.dstAppSeed;
      dstRef_ff <= cfg.dstRefSeed;
    end else if (state_ff == ST_NEXT && emitTup) begin
      if (cfg_ff.dstAppInc) begin
        dstApp_ff <= dstApp_ff + 16'h0001; // [R12] [R16] [R21]
      end
      if (cfg_ff.dstRefInc) begin
        dstRef_ff <= dstRef_ff + 32'h0000_0001; // [R12] [R16] [R21]
      end
    end
  end

  // Completed bytes advance only after a block passes all checks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bytesDone_ff <= '0;
    end else if (state_ff == ST_IDLE && start) begin
      bytesDone_ff <= '0;
    end else if (state_ff == ST_NEXT) begin
      bytesDone_ff <= nxtBytes; // [R14] [R22]
    end
  end

  // Failure flags stay until the next job starts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fail_ff <= '0;
    end else if (state_ff == ST_IDLE && start) begin
      fail_ff <= '0;
    end else if (state_ff == ST_EVAL) begin
      fail_ff <= evalFail; // [R22]
    end
  end

  // Completion strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= state_ff == ST_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output FIFO and status

  // Update data already queued stays queued if its tuple fails
  dif_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .inData   (fifoInData),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (outData),
    .outValid (outValid),
    .outReady (outReady)
  );

  assign busy             = state_ff != ST_IDLE || done_ff;
  assign donePulse        = done_ff;
  assign result.bytesDone = bytesDone_ff;
  assign result.srcApp    = expApp_ff;
  assign result.srcRef    = expRef_ff;
  assign result.dstApp    = dstApp_ff;
  assign result.dstRef    = dstRef_ff;
  assign result.fail      = fail_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_tuple_dropped: // [R3]
  assert property (state_ff == ST_TIN |-> !fifoInValid)
    else $error("source tuple pushed to output");

  a_guard_stop: // [R1] [R7]
  assert property (state_ff == ST_EVAL && evalFail.guardFail |=>
                   state_ff == ST_DONE && fail_ff.guardFail)
    else $error("guard mismatch did not stop job");

  a_app_flag: // [R2] [R8]
  assert property (state_ff == ST_EVAL && cfg_ff.chkApp &&
                   tuple_ff[47:32] != expApp_ff |=> fail_ff.appFail)
    else $error("application tag mismatch not flagged");

  a_bytes_unit: // [R14]
  assert property (state_ff == ST_NEXT |=>
                   bytesDone_ff == $past(bytesDone_ff) + $past(unitBytes))
    else $error("bytes completed step wrong");

  a_ref_incr: // [R4] [R21]
  assert property (state_ff == ST_NEXT && hasTup && cfg_ff.srcRefInc |=>
                   expRef_ff == $past(expRef_ff) + 32'h0000_0001)
    else $error("expected reference tag not advanced");

  a_dst_fixed: // [R12] [R16]
  assert property (state_ff == ST_NEXT && !cfg_ff.dstAppInc |=>
                   $stable(dstApp_ff))
    else $error("fixed destination application tag moved");

  a_tuple_len: // [R13] [R17]
  assert property (state_ff == ST_NEXT && emitTup |->
                   $past(state_ff) == ST_TOUT &&
                   $past(byteCnt_ff) == TUPLE_LAST)
    else $error("emitted tuple not eight bytes");

  a_data_len: // [R5]
  assert property (state_ff == ST_TIN && $past(state_ff) == ST_DATA |->
                   $past(byteCnt_ff) == blkLen - 13'h0001)
    else $error("data section length differs from block size");

  a_seed_load: // [R19]
  assert property (state_ff == ST_IDLE && start |=>
                   crc_ff == $past(seedVal))
    else $error("guard seed not loaded");

  a_fail_done: // [R22]
  assert property (state_ff == ST_DONE && fail_ff != 3'b000 |=>
                   donePulse ##1 !busy)
    else $error("failed job did not complete");

endmodule
`default_nettype wire

// file: verilog/dif_fifo.sv
// Small flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dif_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign inReady  = (wrPtr_ff ^ rdPtr_ff) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_ff[rdPtr_ff[AW-1:0]];

  // Storage written only on an accepted push
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire
